// ### nfh_cfg.svh
`ifndef NFH_CFG_SVH
`define NFH_CFG_SVH

// ==========================================================
// Command codes
`define NFH_CMD_READ_MAIN0   8'h00
`define NFH_CMD_READ_MAIN1   8'h01
`define NFH_CMD_READ_SPARE   8'h50
`define NFH_CMD_READ_ID      8'h90
`define NFH_CMD_RESET        8'hff
`define NFH_CMD_PROG_SETUP   8'h80
`define NFH_CMD_PROG_CONFIRM 8'h10
`define NFH_CMD_COPY_MOVE    8'h8a
`define NFH_CMD_ERASE_SETUP  8'h60
`define NFH_CMD_ERASE_CONF   8'hd0
`define NFH_CMD_STATUS       8'h70

// ==========================================================
// Address layout
`define NFH_ADDR_BYTES       3'd4
`define NFH_ADDR_TOP_MASK    8'h03

// ==========================================================
// Bus timing (ns, then cycles at 10 ns)
`define NFH_CLK_NS           10
`define NFH_STROBE_LOW_NS    30
`define NFH_STROBE_HIGH_NS   20
`define NFH_STROBE_LOW_CYC   ((`NFH_STROBE_LOW_NS + `NFH_CLK_NS - 1) / `NFH_CLK_NS)
`define NFH_STROBE_HIGH_CYC  ((`NFH_STROBE_HIGH_NS + `NFH_CLK_NS - 1) / `NFH_CLK_NS)

`endif

// ### nfh_pkg.sv
`default_nettype none
package nfh_pkg;

	// Kind of one bus cycle
	typedef enum logic [1:0] {
		NFH_CYC_CMD  = 2'b00,
		NFH_CYC_ADDR = 2'b01,
		NFH_CYC_DIN  = 2'b10,
		NFH_CYC_DOUT = 2'b11
	} nfh_cyc_t;

	// Strobe engine phases
	typedef enum logic [1:0] {
		NFH_PH_IDLE = 2'b00,
		NFH_PH_LOW  = 2'b01,
		NFH_PH_HIGH = 2'b10
	} nfh_phase_t;

endpackage : nfh_pkg
`default_nettype wire

// ### nfh_strobe.sv
`timescale 1ns/10ps
`default_nettype none
`include "nfh_cfg.svh"

// Generates one write or read strobe pulse, low then high, with fixed widths.
module nfh_strobe
	import nfh_pkg::*;
(
	// Clock and reset
	input  wire logic  i_clk,
	input  wire logic  i_rst_b,
	// Control
	input  wire logic  i_start,
	input  wire logic  i_is_read,
	// Strobes and status
	output logic       o_we_n,
	output logic       o_re_n,
	output logic       o_sample,
	output logic       o_done
);

	nfh_phase_t   ph_r;
	logic [3:0]   cnt_r;
	logic         rd_r;

	// ==========================================================
	// Phase sequencer
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ph_r  <= NFH_PH_IDLE;
			cnt_r <= 4'h0;
			rd_r  <= 1'b0;
		end else begin
			case (ph_r)
				NFH_PH_IDLE: begin
					if (i_start) begin
						ph_r  <= NFH_PH_LOW;
						rd_r  <= i_is_read;
						cnt_r <= 4'(`NFH_STROBE_LOW_CYC - 1);
					end
				end
				NFH_PH_LOW: begin
					if (cnt_r == 4'h0) begin
						ph_r  <= NFH_PH_HIGH;
						cnt_r <= 4'(`NFH_STROBE_HIGH_CYC - 1);
					end else begin
						cnt_r <= cnt_r - 4'h1;
					end
				end
				NFH_PH_HIGH: begin
					if (cnt_r == 4'h0)
						ph_r <= NFH_PH_IDLE;
					else
						cnt_r <= cnt_r - 4'h1;
				end
				default: ph_r <= NFH_PH_IDLE;
			endcase
		end
	end

	// Only one strobe ever moves per cycle, the other stays high
	always_comb begin
		o_we_n = !(ph_r == NFH_PH_LOW && !rd_r);
		o_re_n = !(ph_r == NFH_PH_LOW && rd_r);
	end

	// Read data is taken at the end of the low phase, just before rising
	assign o_sample = (ph_r == NFH_PH_LOW) && rd_r && (cnt_r == 4'h0);
	assign o_done   = (ph_r == NFH_PH_HIGH) && (cnt_r == 4'h0);

endmodule : nfh_strobe
`default_nettype wire

// ### nfh_host.sv
// Contract
// R1 - Device latches on write strobe rise
// R2 - Command latch high only for commands
// R3 - Address latch high only for addresses
// R4 - Device floats bus when deselected; the flash model always drives o_io and the testbench muxes the bus on o_io_oe
// R5 - Read strobe falls advance column
// R6 - Write protect low blocks program/erase
// R7 - Ready/busy open drain, low busy
// R8 - Four x8 address bytes, top masked
// R9 - Half-page bit from read command
// R10 - x16 upper lines low in address
// R11 - Read commands 00h/01h, 50h, 90h
// R12 - Ordered multi-byte command sequences
// R13 - Busy accepts only FFh, 70h
// R14 - Cycle kind by latch enables
// R15 - Data out with latches low, WE high
// R16 - Commands on low eight lines only
// R17 - Device drops out-of-range address bits
// R18 - Wait ready before other commands
`timescale 1ns/10ps
`default_nettype none
`include "nfh_cfg.svh"

module nfh_host
	import nfh_pkg::*;
#(
	parameter int IO_W = 8
) (
	// Clock and reset
	input  wire logic            i_clk,
	input  wire logic            i_rst_b,
	// User request
	input  wire logic            i_req_valid,
	input  wire logic [1:0]      i_req_kind,
	input  wire logic [IO_W-1:0] i_req_data,
	input  wire logic            i_req_wp_ok,
	output logic                 o_req_ready,
	output logic                 o_req_refused,
	// User read data and status
	output logic [IO_W-1:0]      o_rd_data,
	output logic                 o_rd_valid,
	output logic                 o_busy,
	output logic                 o_half_page_select_bit,
	// Flash pins
	output logic                 o_ce_n,
	output logic                 o_cle,
	output logic                 o_ale,
	output logic                 o_we_n,
	output logic                 o_read_strobe_n,
	output logic                 o_wp_n,
	input  wire logic            i_rb,
	input  wire logic [IO_W-1:0] i_io,
	output logic [IO_W-1:0]      o_io,
	output logic                 o_io_oe
);

	logic            rb_s1_r;
	logic            rb_s2_r;
	logic [IO_W-1:0] io_s1_r;
	logic [IO_W-1:0] io_s2_r;
	logic            act_r;
	nfh_cyc_t        kind_r;
	logic [IO_W-1:0] out_r;
	logic            refuse;
	logic            start;
	logic            st_we_n;
	logic            st_re_n;
	logic            st_sample;
	logic            st_done;
	logic [2:0]      addr_cnt_r;
	logic [IO_W-1:0] cmd_val;

	// ==========================================================
	// Pin synchronisers
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			// Pulled-up idle level, else a false busy follows reset
			rb_s1_r <= 1'b1;
			rb_s2_r <= 1'b1;
			io_s1_r <= '0;
			io_s2_r <= '0;
		end else begin
			rb_s1_r <= i_rb;
			rb_s2_r <= rb_s1_r;
			io_s1_r <= i_io;
			io_s2_r <= io_s1_r;
		end
	end

	// R7 wired-or busy
	assign o_busy = !rb_s2_r;

	// Low byte of a request, upper lines forced low
	function automatic logic [IO_W-1:0] low_only(input logic [IO_W-1:0] d);
		low_only      = '0;
		low_only[7:0] = d[7:0];
	endfunction

	// ==========================================================
	// Request acceptance
	// R18 ready wait
	// R13 busy filter
	always_comb begin
		cmd_val = low_only(i_req_data);
		refuse  = 1'b0;
		if (nfh_cyc_t'(i_req_kind) == NFH_CYC_CMD && o_busy &&
		    cmd_val[7:0] != `NFH_CMD_RESET && cmd_val[7:0] != `NFH_CMD_STATUS)
			refuse = 1'b1;
		// R6 protect guard
		if (nfh_cyc_t'(i_req_kind) == NFH_CYC_CMD && !i_req_wp_ok &&
		    (cmd_val[7:0] == `NFH_CMD_PROG_SETUP || cmd_val[7:0] == `NFH_CMD_ERASE_SETUP))
			refuse = 1'b1;
	end

	assign o_req_ready = !act_r;
	assign start       = i_req_valid && !act_r && !refuse;

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b)
			o_req_refused <= 1'b0;
		else
			o_req_refused <= i_req_valid && !act_r && refuse;
	end

	// ==========================================================
	// Cycle state and driven bus value
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			act_r  <= 1'b0;
			kind_r <= NFH_CYC_CMD;
			out_r  <= '0;
		end else if (start) begin
			act_r  <= 1'b1;
			kind_r <= nfh_cyc_t'(i_req_kind);
			case (nfh_cyc_t'(i_req_kind))
				// R16 command low lines
				NFH_CYC_CMD: out_r <= cmd_val;
				// R8 top byte masked
				// R10 upper lines low
				NFH_CYC_ADDR: begin
					if (addr_cnt_r == `NFH_ADDR_BYTES - 3'd1)
						out_r <= low_only(i_req_data) & IO_W'(`NFH_ADDR_TOP_MASK);
					else
						out_r <= low_only(i_req_data);
				end
				NFH_CYC_DIN: out_r <= i_req_data;
				default:     out_r <= '0;
			endcase
		end else if (st_done) begin
			act_r <= 1'b0;
		end
	end

	// Address byte counter restarts at every command
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b)
			addr_cnt_r <= 3'd0;
		else if (start && nfh_cyc_t'(i_req_kind) == NFH_CYC_CMD)
			addr_cnt_r <= 3'd0;
		else if (start && nfh_cyc_t'(i_req_kind) == NFH_CYC_ADDR &&
		         addr_cnt_r != `NFH_ADDR_BYTES - 3'd1)
			addr_cnt_r <= addr_cnt_r + 3'd1;
	end

	// R9 half select tracking
	// R11 read command decode
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b)
			o_half_page_select_bit <= 1'b0;
		else if (start && nfh_cyc_t'(i_req_kind) == NFH_CYC_CMD) begin
			if (cmd_val[7:0] == `NFH_CMD_READ_MAIN1)
				o_half_page_select_bit <= 1'b1;
			else if (cmd_val[7:0] == `NFH_CMD_READ_MAIN0)
				o_half_page_select_bit <= 1'b0;
		end
	end

	// ==========================================================
	// Strobe engine
	// R1 latch on rise
	nfh_strobe u_strobe (
		.i_clk     (i_clk),
		.i_rst_b   (i_rst_b),
		.i_start   (start),
		.i_is_read (nfh_cyc_t'(i_req_kind) == NFH_CYC_DOUT),
		.o_we_n    (st_we_n),
		.o_re_n    (st_re_n),
		.o_sample  (st_sample),
		.o_done    (st_done)
	);

	// R14 cycle classification
	// R2 command latch
	// R3 address latch
	// R15 read with latches low
	always_comb begin
		o_ce_n          = !act_r;
		o_cle           = act_r && kind_r == NFH_CYC_CMD;
		o_ale           = act_r && kind_r == NFH_CYC_ADDR;
		o_we_n          = st_we_n;
		o_read_strobe_n = st_re_n;
		o_io_oe         = act_r && kind_r != NFH_CYC_DOUT;
	end

	assign o_io = out_r;

	// R6 write protect pin
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b)
			o_wp_n <= 1'b0;
		else
			o_wp_n <= i_req_wp_ok;
	end

	// ==========================================================
	// Read capture
	// R5 one word per strobe
	// Sync delay of two cycles is covered by the strobe low width
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_rd_data  <= '0;
			o_rd_valid <= 1'b0;
		end else begin
			o_rd_valid <= st_sample;
			if (st_sample)
				o_rd_data <= io_s2_r;
		end
	end

	// ==========================================================
	// Checks
	a_cle_ale_excl: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		!(o_cle && o_ale)) else $error("cle and ale both high"); // R14
	a_we_only_write: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		!o_we_n |-> (o_io_oe && !o_ce_n && o_read_strobe_n)) else $error("bad write"); // R1
	a_re_no_latch: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		!o_read_strobe_n |-> (!o_cle && !o_ale && o_we_n && !o_io_oe))
		else $error("bad read"); // R15
	a_busy_filter: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(start && o_busy && i_req_kind == 2'b00) |->
		(i_req_data[7:0] == 8'hff || i_req_data[7:0] == 8'h70))
		else $error("command while busy"); // R13
	a_refuse_flag: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(i_req_valid && !act_r && refuse) |=> o_req_refused)
		else $error("refusal not flagged"); // R18
	a_cmd_upper_low: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(o_cle || o_ale) |-> (o_io >> 8) == '0) else $error("upper lines set"); // R16
	a_half_select: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(start && i_req_kind == 2'b00 && i_req_data[7:0] == 8'h01)
		|=> o_half_page_select_bit) else $error("half select missed"); // R9
	a_strobe_done: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		start |-> ##[1:8] st_done) else $error("strobe never ends"); // R12

endmodule : nfh_host
`default_nettype wire

// ### nfh_flash_model.sv
`timescale 1ns/10ps
`default_nettype none
module nfh_flash_model #(
	parameter int   BUSY_NS = 300,
	parameter [7:0] ID_BASE = 8'h5a // Arbitrary value
) (
	// Flash pins
	input  wire logic       i_ce_n,
	input  wire logic       i_cle,
	input  wire logic       i_ale,
	input  wire logic       i_we_n,
	input  wire logic       i_read_strobe_n,
	input  wire logic       i_wp_n,
	input  wire logic [7:0] i_io,
	output logic      [7:0] o_io,
	output logic            o_rb_low
);
	logic [7:0] cmd_r = 8'hff;
	logic [7:0] addr_r [4];
	logic [2:0] acnt_r = 3'h0;
	logic [7:0] din_r = 8'h00;
	logic [7:0] top_raw_r = 8'h00;
	logic [7:0] col_r = 8'h00;
	logic       half_r = 1'b0;
	logic       arm_r = 1'b0;
	int         runs_r = 0;
	initial o_rb_low = 1'b0;
	initial o_io = 8'h00;

	task automatic take_cmd(input logic [7:0] c);
		if (o_rb_low && c != 8'hff && c != 8'h70)
			return;
		cmd_r = c;
		acnt_r = 3'h0;
		col_r = 8'h00;
		if (c == 8'h00 || c == 8'h01)
			half_r = c[0];
		if ((c == 8'h10 || c == 8'hd0) && arm_r && i_wp_n) begin
			runs_r = runs_r + 1;
			o_rb_low = 1'b1;
			o_rb_low <= #(BUSY_NS) 1'b0;
		end
		arm_r = (c == 8'h80 || c == 8'h60);
	endtask : take_cmd

	always @(posedge i_we_n) begin
		if (!i_ce_n && i_read_strobe_n) begin
			if (i_cle && !i_ale)
				take_cmd(i_io);
			else if (i_ale && !i_cle) begin
				if (acnt_r == 3'h3)
					top_raw_r = i_io;
				addr_r[acnt_r[1:0]] = (acnt_r == 3'h3) ? (i_io & 8'h03) : i_io;
				acnt_r = acnt_r + 3'h1;
			end else if (!i_cle && !i_ale && i_wp_n)
				din_r = i_io;
		end
	end

	always @(negedge i_read_strobe_n) begin
		// Select pins move in the same step as the strobe; let them settle
		#1;
		if (!i_ce_n && !i_cle && !i_ale && i_we_n) begin
			case (cmd_r)
				8'h90: o_io = ID_BASE + col_r;
				8'h70: o_io = {1'b0, ~o_rb_low, 6'h00};
				default: o_io = {half_r, col_r[6:0]};
			endcase
			col_r = col_r + 8'h01;
		end
	end

	always @(posedge i_read_strobe_n) o_io = ~o_io;
endmodule : nfh_flash_model
`default_nettype wire

// ### testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench
	import nfh_pkg::*;
;
	logic       i_clk = 1'b0;
	logic       i_rst_b = 1'b0;
	logic       i_req_valid = 1'b0;
	logic [1:0] i_req_kind = 2'h0;
	logic [7:0] i_req_data = 8'h00;
	logic       i_req_wp_ok = 1'b0;
	wire        o_req_ready, o_req_refused, o_rd_valid, o_busy, o_half;
	wire  [7:0] o_rd_data, o_io, m_io, io_bus;
	wire        o_ce_n, o_cle, o_ale, o_we_n, o_re_n, o_wp_n, o_io_oe, rb_low;
	int         err_total = 0;
	int         samples_checked = 0;
	int         cyc = 0;
	assign io_bus = o_io_oe ? o_io : m_io;

	nfh_host #(.IO_W(8)) dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_req_valid(i_req_valid),
		.i_req_kind(i_req_kind), .i_req_data(i_req_data), .i_req_wp_ok(i_req_wp_ok),
		.o_req_ready(o_req_ready), .o_req_refused(o_req_refused), .o_rd_data(o_rd_data),
		.o_rd_valid(o_rd_valid), .o_busy(o_busy), .o_half_page_select_bit(o_half),
		.o_ce_n(o_ce_n), .o_cle(o_cle), .o_ale(o_ale), .o_we_n(o_we_n),
		.o_read_strobe_n(o_re_n), .o_wp_n(o_wp_n), .i_rb(~rb_low), .i_io(io_bus),
		.o_io(o_io), .o_io_oe(o_io_oe));
	// Busy long enough that the status read surely lands inside it
	nfh_flash_model #(.BUSY_NS(600)) mdl (.i_ce_n(o_ce_n), .i_cle(o_cle), .i_ale(o_ale),
		.i_we_n(o_we_n),
		.i_read_strobe_n(o_re_n), .i_wp_n(o_wp_n), .i_io(io_bus), .o_io(m_io),
		.o_rb_low(rb_low));

	initial forever #5 i_clk = ~i_clk;
	// ==========================================================
	// Checking and bus tasks
	task automatic end_sim;
		$display("checked %0d errors %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : end_sim

	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 3000) begin
			err_total++;
			$display("FAIL %0t timeout", $time);
			end_sim();
		end
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk

	// Eight edges after the take covers answer and ready return
	task automatic send(input nfh_cyc_t k, input logic [7:0] d, output logic rf,
		output logic [7:0] rd);
		int n;
		n = 0;
		rf = 1'b0;
		rd = 8'hxx;
		do begin
			@(posedge i_clk);
			n++;
		end while (!o_req_ready && n < 50);
		i_req_valid <= 1'b1;
		i_req_kind <= k;
		i_req_data <= d;
		@(posedge i_clk);
		i_req_valid <= 1'b0;
		repeat (8) begin
			@(posedge i_clk);
			if (o_req_refused === 1'b1)
				rf = 1'b1;
			if (o_rd_valid === 1'b1)
				rd = o_rd_data;
		end
	endtask : send

	// ==========================================================
	// Scenarios
	task automatic s_read_id;
		logic rf;
		logic [7:0] rd;
		send(NFH_CYC_CMD, 8'h90, rf, rd);
		send(NFH_CYC_ADDR, 8'h00, rf, rd);
		send(NFH_CYC_DOUT, 8'h00, rf, rd);
		chk(rd, 8'h5a, "id first");
		send(NFH_CYC_DOUT, 8'h00, rf, rd);
		chk(rd, 8'h5b, "id next");
		send(NFH_CYC_CMD, 8'h01, rf, rd);
		chk({7'h00, o_half}, 8'h01, "half hi");
		send(NFH_CYC_DOUT, 8'h00, rf, rd);
		chk(rd, 8'h80, "main hi");
		send(NFH_CYC_CMD, 8'h00, rf, rd);
		chk({7'h00, o_half}, 8'h00, "half lo");
	endtask : s_read_id

	task automatic s_program;
		logic rf;
		logic [7:0] rd;
		int n;
		i_req_wp_ok <= 1'b1;
		send(NFH_CYC_CMD, 8'h80, rf, rd);
		send(NFH_CYC_ADDR, 8'h11, rf, rd);
		send(NFH_CYC_ADDR, 8'h22, rf, rd);
		send(NFH_CYC_ADDR, 8'h33, rf, rd);
		send(NFH_CYC_ADDR, 8'hff, rf, rd);
		chk(mdl.addr_r[0], 8'h11, "addr first");
		chk(mdl.addr_r[3], 8'h03, "addr top");
		chk(mdl.top_raw_r, 8'h03, "addr top raw");
		send(NFH_CYC_DIN, 8'ha5, rf, rd);
		chk(mdl.din_r, 8'ha5, "data in");
		send(NFH_CYC_CMD, 8'h10, rf, rd);
		chk({7'h00, o_busy}, 8'h01, "busy");
		send(NFH_CYC_CMD, 8'h90, rf, rd);
		chk({7'h00, rf}, 8'h01, "busy refuse");
		send(NFH_CYC_CMD, 8'h70, rf, rd);
		chk({7'h00, rf}, 8'h00, "status ok");
		send(NFH_CYC_DOUT, 8'h00, rf, rd);
		chk(rd, 8'h00, "status busy");
		n = 0;
		while (o_busy !== 1'b0 && n < 200) begin
			@(posedge i_clk);
			n++;
		end
		chk(mdl.runs_r[7:0], 8'h01, "program ran");
		send(NFH_CYC_DOUT, 8'h00, rf, rd);
		chk(rd, 8'h40, "status ready");
	endtask : s_program

	task automatic s_protect;
		logic rf;
		logic [7:0] rd;
		i_req_wp_ok <= 1'b0;
		send(NFH_CYC_CMD, 8'h80, rf, rd);
		chk({7'h00, rf}, 8'h01, "wp prog");
		send(NFH_CYC_CMD, 8'h60, rf, rd);
		chk({7'h00, rf}, 8'h01, "wp erase");
		chk({7'h00, o_wp_n}, 8'h00, "wp pin");
		i_req_wp_ok <= 1'b1;
		send(NFH_CYC_CMD, 8'h60, rf, rd);
		repeat (3) send(NFH_CYC_ADDR, 8'h00, rf, rd);
		send(NFH_CYC_CMD, 8'hd0, rf, rd);
		chk(mdl.runs_r[7:0], 8'h02, "erase ran");
		send(NFH_CYC_CMD, 8'hff, rf, rd);
		chk({7'h00, rf}, 8'h00, "reset ok");
		chk(mdl.cmd_r, 8'hff, "reset taken");
	endtask : s_protect

	initial begin
		repeat (3) @(posedge i_clk);
		chk({7'h00, o_ce_n}, 8'h01, "reset ce");
		i_rst_b <= 1'b1;
		s_read_id();
		s_program();
		s_protect();
		end_sim();
	end
endmodule : testbench
`default_nettype wire
